// [inc/cmf_pkg.sv]
`default_nettype none
package cmf_pkg;
   // Register byte addresses on the AXI4-Lite port.
   localparam logic [7:0]  ADDR_CTRL1      = 8'h00;
   localparam logic [7:0]  ADDR_FILT_EN    = 8'h04;
   localparam logic [7:0]  ADDR_FILT_HIT   = 8'h08;
   // Field positions inside the first control word.
   localparam int          REQ_LSB         = 8;
   localparam int          CUR_LSB         = 5;
   localparam int          MODE_W          = 3;
   localparam int          NUM_FILT        = 16;
   // Reset values.
   localparam logic [2:0]  MODE_RST        = 3'h4;
   localparam logic [15:0] FILT_EN_RST     = 16'hFFFF;
   // Bus idle needs this many consecutive recessive bit periods.
   localparam int          IDLE_BITS       = 11;
   // Bit period in ns and the cycles it takes at the 100 ns clock.
   localparam int          CLK_NS          = 100;
   localparam int          BIT_NS          = 2000;
   localparam int          BIT_CYC         = (BIT_NS + CLK_NS - 1) / CLK_NS;
   // Operating modes; encodings are arbitrary codes of this block.
   localparam logic [2:0]  MODE_NORMAL     = 3'h0;
   localparam logic [2:0]  MODE_DISABLE    = 3'h1;
   localparam logic [2:0]  MODE_LOOPBACK   = 3'h2;
   localparam logic [2:0]  MODE_LISTEN     = 3'h3;
   localparam logic [2:0]  MODE_INIT       = 3'h4;
   localparam logic [2:0]  MODE_LISTEN_ALL = 3'h7;
   // AXI responses.
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage : cmf_pkg
`default_nettype wire

// [inc/cmf_idle_if.sv]
`default_nettype none
// Carries the bit tick and the idle verdict between the timer and the core.
interface cmf_idle_if;
   logic bit_tick;
   logic bus_idle;
   modport timer (output bit_tick, output bus_idle);
   modport core  (input bit_tick, input bus_idle);
endinterface : cmf_idle_if
`default_nettype wire

// [verilog/cmf_idle_timer.sv]
`default_nettype none
module cmf_idle_timer #(
   parameter int BIT_CYC   = cmf_pkg::BIT_CYC,
   parameter int IDLE_BITS = cmf_pkg::IDLE_BITS
) (
   input  wire logic  i_mclk,
   input  wire logic  i_rst_b,
   input  wire logic  i_can_rx,
   cmf_idle_if.timer  idle
);
   logic [15:0] div_r;
   logic [4:0]  run_r;

   ////////////////////////////////////////////////////////////////////
   // Bit-rate divider; one tick per bit period.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         div_r <= 16'h0000;
      else if (div_r == 16'(BIT_CYC - 1))
         div_r <= 16'h0000;
      else
         div_r <= div_r + 16'h0001;
   end
   assign idle.bit_tick = (div_r == 16'(BIT_CYC - 1));

   // RULE5 recessive run count
   // A dominant level at any sample restarts the run, so a glitch costs idle.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         run_r <= 5'h00;
      else if (!i_can_rx)
         run_r <= 5'h00;
      else if (idle.bit_tick && run_r != 5'(IDLE_BITS))
         run_r <= run_r + 5'h01;
   end
   assign idle.bus_idle = (run_r == 5'(IDLE_BITS));

   // RULE5 idle needs the last sample recessive
   chk_idle_needs_run: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE5
      idle.bus_idle |-> $past(i_can_rx))
      else $error("Idle claimed after a dominant sample.");
endmodule : cmf_idle_timer
`default_nettype wire

// [verilog/cmf_mode_ctrl.sv]
// What this block does
// RULE1 - six software-selectable operating modes
// RULE2 - software writes mode request at bits 10:8
// RULE3 - current mode readable at bits 7:5
// RULE4 - mode held until switching is acceptable
// RULE5 - idle means eleven consecutive recessive bits
// RULE6 - sixteen bits enable or disable filters
// RULE7 - disabled filters never report a match
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
module cmf_mode_ctrl #(
   parameter int NUM_FILT = cmf_pkg::NUM_FILT
) (
   input  wire logic                i_mclk,
   input  wire logic                i_rst_b,
   input  wire logic [7:0]          i_awaddr,
   input  wire logic                i_awvalid,
   output logic                     o_awready,
   input  wire logic [31:0]         i_wdata,
   input  wire logic [3:0]          i_wstrb,
   input  wire logic                i_wvalid,
   output logic                     o_wready,
   output logic [1:0]               o_bresp,
   output logic                     o_bvalid,
   input  wire logic                i_bready,
   input  wire logic [7:0]          i_araddr,
   input  wire logic                i_arvalid,
   output logic                     o_arready,
   output logic [31:0]              o_rdata,
   output logic [1:0]               o_rresp,
   output logic                     o_rvalid,
   input  wire logic                i_rready,
   input  wire logic                i_can_rx,
   input  wire logic [NUM_FILT-1:0] i_filt_raw_hit,
   input  wire logic                i_msg_done,
   output logic [2:0]               o_op_mode,
   output logic [NUM_FILT-1:0]      o_filt_hit,
   output logic                     o_msg_store
);
   cmf_idle_if idle ();

   logic [2:0]          req_r;
   logic [2:0]          cur_r;
   logic [15:0]         fen_r;
   logic [15:0]         hit_r;
   logic                store_r;
   logic                aw_got_r;
   logic                w_got_r;
   logic [7:0]          awaddr_r;
   logic [31:0]         wdata_r;
   logic [3:0]          wstrb_r;
   logic                wr_go;
   logic [15:0]         fen_nxt;

   ////////////////////////////////////////////////////////////////////
   // Idle detection and bit tick come from the timer.
   cmf_idle_timer u_idle (
      .i_mclk   (i_mclk),
      .i_rst_b  (i_rst_b),
      .i_can_rx (i_can_rx),
      .idle     (idle)
   );

   // Only the six documented codes are legal requests.
   function automatic logic mode_legal(input logic [2:0] m);
      // RULE1 six mode codes
      mode_legal = (m == cmf_pkg::MODE_NORMAL) || (m == cmf_pkg::MODE_DISABLE) ||
                   (m == cmf_pkg::MODE_LOOPBACK) || (m == cmf_pkg::MODE_LISTEN) ||
                   (m == cmf_pkg::MODE_INIT) || (m == cmf_pkg::MODE_LISTEN_ALL);
   endfunction : mode_legal

   ////////////////////////////////////////////////////////////////////
   // Write channel capture; address and data are taken in either order.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r  <= 32'h0000_0000;
         wstrb_r  <= 4'h0;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            aw_got_r <= 1'b1;
            awaddr_r <= i_awaddr;
         end
         else if (wr_go)
            aw_got_r <= 1'b0;
         if (i_wvalid && o_wready)
         begin
            w_got_r <= 1'b1;
            wdata_r <= i_wdata;
            wstrb_r <= i_wstrb;
         end
         else if (wr_go)
            w_got_r <= 1'b0;
      end
   end
   assign o_awready = !aw_got_r && !o_bvalid;
   assign o_wready  = !w_got_r && !o_bvalid;
   assign wr_go     = aw_got_r && w_got_r;

   // Write response, one cycle after both halves are held.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_bvalid <= 1'b0;
         o_bresp  <= cmf_pkg::RESP_OKAY;
      end
      else if (wr_go)
      begin
         o_bvalid <= 1'b1;
         o_bresp  <= (awaddr_r == cmf_pkg::ADDR_CTRL1 || awaddr_r == cmf_pkg::ADDR_FILT_EN)
                     ? cmf_pkg::RESP_OKAY : cmf_pkg::RESP_SLVERR;
      end
      else if (o_bvalid && i_bready)
         o_bvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////
   // RULE2 mode request write
   // An illegal code is dropped so the request field always names a real mode.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         req_r <= cmf_pkg::MODE_RST;
      else if (wr_go && awaddr_r == cmf_pkg::ADDR_CTRL1 && wstrb_r[1] &&
               mode_legal(wdata_r[cmf_pkg::REQ_LSB +: cmf_pkg::MODE_W]))
         req_r <= wdata_r[cmf_pkg::REQ_LSB +: cmf_pkg::MODE_W];
   end

   // RULE4 switch only when idle
   // Entering init or disable is also held for idle, so no frame is cut short.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         cur_r <= cmf_pkg::MODE_RST;
      else if (req_r != cur_r && idle.bus_idle)
         cur_r <= req_r;
   end
   assign o_op_mode = cur_r;

   // RULE6 filter enable write
   always_comb
   begin
      fen_nxt = fen_r;
      if (wstrb_r[0])
         fen_nxt[7:0] = wdata_r[7:0];
      if (wstrb_r[1])
         fen_nxt[15:8] = wdata_r[15:8];
   end

   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         fen_r <= cmf_pkg::FILT_EN_RST;
      else if (wr_go && awaddr_r == cmf_pkg::ADDR_FILT_EN)
         fen_r <= fen_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // RULE7 gate filter hits
   // Matches are registered at the end of a message; store needs a live mode.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         hit_r   <= 16'h0000;
         store_r <= 1'b0;
      end
      else
      begin
         store_r <= 1'b0;
         if (i_msg_done)
         begin
            hit_r   <= 16'(i_filt_raw_hit) & fen_r;
            store_r <= |(16'(i_filt_raw_hit) & fen_r) &&
                       cur_r != cmf_pkg::MODE_INIT && cur_r != cmf_pkg::MODE_DISABLE;
         end
      end
   end
   assign o_filt_hit  = hit_r[NUM_FILT-1:0];
   assign o_msg_store = store_r;

   ////////////////////////////////////////////////////////////////////
   // RULE3 current mode readback
   // Reads answer one cycle after the address is taken.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0000_0000;
         o_rresp  <= cmf_pkg::RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         o_rvalid <= 1'b1;
         o_rresp  <= cmf_pkg::RESP_OKAY;
         case (i_araddr)
            cmf_pkg::ADDR_CTRL1:
               o_rdata <= {21'h000000, req_r, cur_r, 5'h00};
            cmf_pkg::ADDR_FILT_EN:
               o_rdata <= {16'h0000, fen_r};
            cmf_pkg::ADDR_FILT_HIT:
               o_rdata <= {16'h0000, hit_r};
            default:
            begin
               o_rdata <= 32'h0000_0000;
               o_rresp <= cmf_pkg::RESP_SLVERR;
            end
         endcase
      end
      else if (o_rvalid && i_rready)
         o_rvalid <= 1'b0;
   end
   assign o_arready = !o_rvalid;

   ////////////////////////////////////////////////////////////////////
   // RULE4 mode held busy
   chk_mode_hold_busy: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE4
      !$past(idle.bus_idle) |-> $stable(cur_r))
      else $error("Mode changed while the bus was not idle.");

   // RULE4 switch when idle
   chk_mode_follows_req: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE4
      (req_r != cur_r && idle.bus_idle) |=> (cur_r == $past(req_r)))
      else $error("Idle bus did not take the requested mode.");

   // RULE3 readback matches mode
   chk_read_cur_mode: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE3
      (i_arvalid && o_arready && i_araddr == cmf_pkg::ADDR_CTRL1)
      |=> (o_rvalid && o_rdata[7:5] == $past(cur_r)))
      else $error("Current-mode field differs from the mode in effect.");

   // RULE1 mode stays legal
   chk_mode_legal: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE1
      mode_legal(cur_r) && mode_legal(req_r))
      else $error("Mode register holds an undefined code.");

   // RULE7 no disabled hit
   chk_no_dis_hit: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE7
      $past(i_msg_done) |-> ((hit_r & ~$past(fen_r)) == 16'h0000))
      else $error("A disabled filter reported a match.");

   // RULE7 store needs enabled hit
   chk_store_cause: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE7
      o_msg_store |-> (hit_r != 16'h0000))
      else $error("Message stored without an enabled filter match.");

   // RULE6 enable write lands
   chk_fen_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE6
      (wr_go && awaddr_r == cmf_pkg::ADDR_FILT_EN && wstrb_r == 4'hF)
      |=> (fen_r == $past(wdata_r[15:0])))
      else $error("Filter enable write was not stored.");

   // RULE2 request write lands
   chk_req_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE2
      (wr_go && awaddr_r == cmf_pkg::ADDR_CTRL1 && wstrb_r[1] && wdata_r[10:8] == 3'h3)
      |=> (req_r == 3'h3))
      else $error("Mode request write was not stored.");

   // RULE7 store in live mode
   chk_store_live_mode: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE7
      o_msg_store |-> ($past(cur_r) != cmf_pkg::MODE_INIT &&
                       $past(cur_r) != cmf_pkg::MODE_DISABLE))
      else $error("Message stored while the controller was off the bus.");

   // RULE7 enabled hit stores
   chk_store_on_hit: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE7
      ($past(i_msg_done) && hit_r != 16'h0000 && $past(cur_r) != cmf_pkg::MODE_INIT &&
       $past(cur_r) != cmf_pkg::MODE_DISABLE) |-> o_msg_store)
      else $error("Enabled filter match in a live mode was not stored.");

   // RULE6 enables held otherwise
   chk_fen_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE6
      !(wr_go && awaddr_r == cmf_pkg::ADDR_FILT_EN) |=> $stable(fen_r))
      else $error("Filter enables changed without a write.");

   // RULE2 request held otherwise
   chk_req_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE2
      !(wr_go && awaddr_r == cmf_pkg::ADDR_CTRL1) |=> $stable(req_r))
      else $error("Mode request changed without a write.");

   // RULE6 enable readback
   chk_read_fen: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE6
      (i_arvalid && o_arready && i_araddr == cmf_pkg::ADDR_FILT_EN)
      |=> (o_rvalid && o_rdata[15:0] == $past(fen_r)))
      else $error("Filter enable readback differs from the stored enables.");

   // Unmapped reads answer with an error and zero data.
   chk_rd_unmapped: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      (i_arvalid && o_arready && i_araddr != cmf_pkg::ADDR_CTRL1 &&
       i_araddr != cmf_pkg::ADDR_FILT_EN && i_araddr != cmf_pkg::ADDR_FILT_HIT)
      |=> (o_rresp == cmf_pkg::RESP_SLVERR && o_rdata == 32'h0000_0000))
      else $error("Unmapped read did not answer with an error.");

   // Write answer timing.
   chk_bresp_timing: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
      wr_go |=> o_bvalid)
      else $error("Write response missing one cycle after both halves.");
endmodule : cmf_mode_ctrl
`default_nettype wire

// [bench/cmf_can_node.sv]
`default_nettype none
// Far-side node: one frame of alternating bits, then the bus is left recessive.
module cmf_can_node #(
   parameter int BIT_CYC = 20,
   parameter int NBITS   = 9
) (
   input  wire logic i_mclk,
   input  wire logic i_rst_b,
   input  wire logic i_send,
   output logic      o_can_rx,
   output logic      o_busy
);
   timeunit 1ns;
   timeprecision 1ns;
   int cyc_r;
   // An odd bit count makes the frame end on a dominant bit, a clean start for the idle run.
   always_ff @(posedge i_mclk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         cyc_r <= 0;
      else if (i_send && cyc_r == 0)
         cyc_r <= 1;
      else if (cyc_r != 0)
         cyc_r <= (cyc_r == BIT_CYC * NBITS) ? 0 : cyc_r + 1;
   end
   // Released bus sits at the recessive pull-up level.
   assign o_busy   = (cyc_r != 0);
   assign o_can_rx = o_busy ? (((cyc_r - 1) / BIT_CYC) % 2 == 1) : 1'b1;
endmodule : cmf_can_node
`default_nettype wire

// [bench/can_mode_and_filter_enable_tb_top.sv]
`default_nettype none
module can_mode_and_filter_enable_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_mclk;
   logic        i_rst_b;
   logic        awv, wv, arv, done, send, rx, busy, awr, wr, arr, bv, rv, store;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rd, seed, rdv;
   logic [3:0]  ws;
   logic [1:0]  br, rr, r;
   logic [2:0]  mode;
   logic [15:0] raw, hit;
   int          num_errors;
   int          check_count;
   logic [2:0]  codes [6] = '{cmf_pkg::MODE_NORMAL, cmf_pkg::MODE_DISABLE,
                              cmf_pkg::MODE_LOOPBACK, cmf_pkg::MODE_LISTEN,
                              cmf_pkg::MODE_LISTEN_ALL, cmf_pkg::MODE_INIT};
   // Negedges from the end of the last dominant bit to the new mode: the bit tick
   // phase is free, so the window spans one bit period.
   localparam int IDLE_MIN = (cmf_pkg::IDLE_BITS - 1) * cmf_pkg::BIT_CYC + 2;
   localparam int IDLE_MAX = cmf_pkg::IDLE_BITS * cmf_pkg::BIT_CYC + 1;

   cmf_mode_ctrl dut_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_awaddr(awa), .i_awvalid(awv),
      .o_awready(awr), .i_wdata(wd), .i_wstrb(ws), .i_wvalid(wv), .o_wready(wr),
      .o_bresp(br), .o_bvalid(bv), .i_bready(1'b1), .i_araddr(ara), .i_arvalid(arv),
      .o_arready(arr), .o_rdata(rd), .o_rresp(rr), .o_rvalid(rv), .i_rready(1'b1),
      .i_can_rx(rx), .i_filt_raw_hit(raw), .i_msg_done(done), .o_op_mode(mode),
      .o_filt_hit(hit), .o_msg_store(store));
   cmf_can_node #(.BIT_CYC(cmf_pkg::BIT_CYC)) node_u (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
      .i_send(send), .o_can_rx(rx), .o_busy(busy));

   initial
   begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   // Storing is held off in init and disable modes.
   function automatic logic exp_store(input logic [15:0] h, input logic [2:0] m);
      return |h && m != cmf_pkg::MODE_INIT && m != cmf_pkg::MODE_DISABLE;
   endfunction : exp_store
   // Control word as software reads it: request field above current-mode field.
   function automatic logic [31:0] exp_ctrl(input logic [2:0] q, input logic [2:0] c);
      return (32'(q) << cmf_pkg::REQ_LSB) | (32'(c) << cmf_pkg::CUR_LSB);
   endfunction : exp_ctrl
   task automatic finish_test();
      $display("errors=%0d checks=%0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   task automatic tmo();
      num_errors++;
      finish_test();
   endtask : tmo
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // Readiness is sampled at the falling edge, where it is settled, and acted on after the rise.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] p);
      logic ta, tw, tb;
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(negedge i_mclk);
         ta = awv & awr;
         tw = wv & wr;
         tb = bv;
         p = br;
         @(posedge i_mclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tb) return;
      end
      tmo();
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] p);
      logic ta, tr;
      ara <= a;
      arv <= 1'b1;
      for (int n = 0; n < 40; n++)
      begin
         @(negedge i_mclk);
         ta = arv & arr;
         tr = rv;
         d = rd;
         p = rr;
         @(posedge i_mclk);
         if (ta) arv <= 1'b0;
         if (tr) return;
      end
      tmo();
   endtask : axi_rd
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0]  p;
      axi_rd(a, d, p);
      chk(d, e);
      chk(p, cmf_pkg::RESP_OKAY);
   endtask : rd_chk
   // One received message with random raw hits against a given enable mask.
   task automatic filt(input logic [15:0] en, input logic [2:0] m);
      logic [1:0]  p;
      logic [15:0] h;
      seed = xs(seed);
      h = seed[31:16];
      axi_wr(cmf_pkg::ADDR_FILT_EN, {16'hA5A5, en}, p);
      rd_chk(cmf_pkg::ADDR_FILT_EN, {16'h0000, en});
      raw <= h;
      done <= 1'b1;
      @(posedge i_mclk);
      done <= 1'b0;
      @(negedge i_mclk);
      chk(hit, h & en);
      chk(store, exp_store(h & en, m));
      @(posedge i_mclk);
      rd_chk(cmf_pkg::ADDR_FILT_HIT, {16'h0000, h & en});
   endtask : filt

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset values, every mode behind a busy bus, filters in each mode.
   initial
   begin
      int n;
      {i_rst_b, awv, wv, arv, done, send, awa, ara, wd, raw} = '0;
      ws = 4'hF;
      num_errors = 0;
      check_count = 0;
      seed = 32'h38;
      repeat (16) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      @(posedge i_mclk);
      rd_chk(cmf_pkg::ADDR_CTRL1, exp_ctrl(cmf_pkg::MODE_RST, cmf_pkg::MODE_RST));
      rd_chk(cmf_pkg::ADDR_FILT_EN, {16'h0000, cmf_pkg::FILT_EN_RST});
      axi_rd(8'h0C, rdv, r);
      chk(rdv, 32'h0000_0000);
      chk(r, cmf_pkg::RESP_SLVERR);
      axi_wr(8'h0C, 32'hFFFF_FFFF, r);
      chk(r, cmf_pkg::RESP_SLVERR);
      foreach (codes[i])
      begin
         send <= 1'b1;
         @(posedge i_mclk);
         send <= 1'b0;
         axi_wr(cmf_pkg::ADDR_CTRL1, {21'h0, codes[i], 8'h00}, r);
         for (n = 0; busy; n++)
         begin
            if (n > 300) tmo();
            @(negedge i_mclk);
         end
         chk(mode, (i == 0) ? cmf_pkg::MODE_INIT : codes[i - 1]);
         for (n = 0; mode !== codes[i]; n++)
         begin
            if (n > 300) tmo();
            @(negedge i_mclk);
         end
         chk(n >= IDLE_MIN && n <= IDLE_MAX, 1'b1);
         @(posedge i_mclk);
         rd_chk(cmf_pkg::ADDR_CTRL1, exp_ctrl(codes[i], codes[i]));
         seed = xs(seed);
         filt((i == 2) ? 16'h0000 : seed[15:0], codes[i]);
         filt(16'hFFFF, codes[i]);
      end
      // Unused code 5 is refused while the bus idles, so nothing may move.
      axi_wr(cmf_pkg::ADDR_CTRL1, 32'h0000_0500, r);
      chk(r, cmf_pkg::RESP_OKAY);
      repeat (4) @(posedge i_mclk);
      rd_chk(cmf_pkg::ADDR_CTRL1, exp_ctrl(cmf_pkg::MODE_INIT, cmf_pkg::MODE_INIT));
      // With only the low strobe set, the request byte stays and the low enables land.
      ws <= 4'h1;
      axi_wr(cmf_pkg::ADDR_CTRL1, 32'h0000_0312, r);
      axi_wr(cmf_pkg::ADDR_FILT_EN, 32'h0000_0312, r);
      ws <= 4'hF;
      rd_chk(cmf_pkg::ADDR_CTRL1, exp_ctrl(cmf_pkg::MODE_INIT, cmf_pkg::MODE_INIT));
      rd_chk(cmf_pkg::ADDR_FILT_EN, 32'h0000_FF12);
      // A reset in mid-run restores the reset mode, the enables and the hit record.
      i_rst_b <= 1'b0;
      repeat (4) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      @(posedge i_mclk);
      rd_chk(cmf_pkg::ADDR_FILT_EN, {16'h0000, cmf_pkg::FILT_EN_RST});
      rd_chk(cmf_pkg::ADDR_FILT_HIT, 32'h0000_0000);
      rd_chk(cmf_pkg::ADDR_CTRL1, exp_ctrl(cmf_pkg::MODE_RST, cmf_pkg::MODE_RST));
      finish_test();
   end
endmodule : can_mode_and_filter_enable_tb_top
`default_nettype wire
